// [rtl/conv_ctrl_pkg.sv]
// constants shared by the converter control block and its helpers
// assumes a 32-bit classic wishbone slave with word-aligned registers
package conv_ctrl_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_CTRL2 = 8'h08;
  localparam logic [7:0] OFF_RES_HI = 8'h0c;
  localparam logic [7:0] OFF_RES_LO = 8'h10;
  localparam logic [7:0] OFF_INT = 8'h14;
  localparam logic [7:0] OFF_PINSEL = 8'h18;
  localparam logic [7:0] OFF_SAMPLE = 8'h1c;
  // control reg 0 fields
  localparam int CTRL0_START = 7;
  localparam int CTRL0_BUSY = 6;
  localparam int CTRL0_PWR = 5;
  localparam int CTRL0_ALIGN = 4;
  // control reg 1 fields
  localparam int CTRL1_SRC_LSB = 4;
  // control reg 2 fields
  localparam int CTRL2_REF_LSB = 2;
  // interrupt control fields
  localparam int INT_GIE = 0;
  localparam int INT_CIE = 1;
  localparam int INT_REQ = 2;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // conversion timing, in converter clocks
  localparam int SAMPLE_CLKS = 4;
  localparam int CONVERT_CLKS = 12;
  localparam int TOTAL_CLKS = SAMPLE_CLKS + CONVERT_CLKS;
  localparam logic [4:0] LAST_CLK = 5'(TOTAL_CLKS - 1);
  localparam int RES_BITS = 12;
  // converter input source codes
  localparam logic [3:0] SRC_EXT = 4'h0;
  localparam logic [3:0] SRC_VDD = 4'h1;
  localparam logic [3:0] SRC_VDD2 = 4'h2;
  localparam logic [3:0] SRC_VDD4 = 4'h3;
  localparam logic [3:0] SRC_AMP = 4'h5;
  localparam logic [3:0] SRC_AMP2 = 4'h6;
  localparam logic [3:0] SRC_AMP4 = 4'h7;
  localparam logic [3:0] SRC_GND = 4'h8;
  // reference choices
  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [1:0] REF_PIN = 2'h1;
  localparam logic [1:0] REF_AMP = 2'h2;
  typedef enum logic [1:0] {CV_IDLE, CV_RESET, CV_RUN} conv_state_t;
endpackage

// [rtl/clock_divider.sv]
// power-of-two divider making the converter clock tick
// assumes a single system clock; the tick is one mclk cycle wide
`timescale 1ns/1ps
module clock_divider (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clear,
  input wire logic [2:0] div_sel,
  output logic tick
);
  // free counter, restarted so every conversion starts aligned
  logic [6:0] count_reg;
  logic [6:0] limit;

  // 000 passes every cycle, each code step doubles the ratio
  always_comb begin
    limit = 7'((8'h01 << div_sel) - 8'h01);
  end

  // counter wraps at the chosen limit
  always_ff @(posedge mclk) begin
    if (reset || clear || count_reg >= limit) begin
      count_reg <= 7'h00;
    end else begin
      count_reg <= count_reg + 7'h01;
    end
  end

  // tick on wrap, so divide by 1 ticks every cycle
  assign tick = !clear && (count_reg >= limit);
endmodule

// [rtl/sar_step.sv]
// successive approximation register: one bit per converter clock
// assumes the comparator input is already stable in mclk's domain
`timescale 1ns/1ps
module sar_step #(
  parameter int WIDTH = 12
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic load,
  input wire logic step,
  input wire logic cmp_high,
  output logic [WIDTH-1:0] trial,
  output logic done
);
  // bit under test, one-hot, walks from msb to lsb
  logic [WIDTH-1:0] probe_reg;
  logic [WIDTH-1:0] trial_reg;

  // keep or drop the probed bit, then try the next one down
  always_ff @(posedge mclk) begin
    if (reset) begin
      probe_reg <= '0;
      trial_reg <= '0;
    end else if (load) begin
      probe_reg <= {1'b1, {(WIDTH-1){1'b0}}};
      trial_reg <= {1'b1, {(WIDTH-1){1'b0}}};
    end else if (step && probe_reg != '0) begin
      probe_reg <= probe_reg >> 1;
      // drop the bit when the trial overshoots the input
      trial_reg <= (cmp_high ? trial_reg : (trial_reg & ~probe_reg))
                   | (probe_reg >> 1);
    end
  end

  assign trial = trial_reg;
  assign done = (probe_reg == '0);
endmodule

// [rtl/sar_conv_ctrl.sv]
// control of one 12-bit successive-approximation converter
// assumes wishbone classic master on mclk; analog parts sit outside
// What this block does
// - external pin chosen for codes 0,4,c-f
// - internal sources routed per code, channel ignored
// - codes 8 to b ground the input
// - internal source always disconnects the external path
// - busy set on start release, cleared on completion
// - completion sets request, interrupt when enabled
// - divider code doubles ratio, 000 to /128
// - four sampling plus twelve conversion clocks
// - analog pin drops pull-up, function, direction
// - reference: supply, pin, or amplifier output
// - alignment bit selects left or right result
// - start held high keeps converter in reset
// - power off leaves result registers unchanged
`timescale 1ns/1ps
module sar_conv_ctrl
  import conv_ctrl_pkg::*;
#(
  parameter int PINS = 4
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cmp_high,
  output logic [11:0] dac_code,
  output logic sample_on,
  output logic conv_reset,
  output logic converter_power,
  output logic [PINS-1:0] ext_path_on,
  output logic [3:0] internal_source,
  output logic input_grounded,
  output logic [2:0] reference_route,
  output logic [PINS-1:0] pin_analog_mode,
  output logic [PINS-1:0] pin_pullup_disable,
  output logic [PINS-1:0] pin_dir_override,
  output logic conv_irq
);
  import conv_ctrl_pkg::*;

  // software-visible control fields
  logic start_reg;
  logic power_reg;
  logic align_reg;
  logic [1:0] chan_reg;
  logic [3:0] src_reg;
  logic [2:0] div_reg;
  logic [7:0] ctrl2_reg;
  logic gie_reg;
  logic cie_reg;
  logic req_reg;
  logic [PINS-1:0] pinsel_reg;
  logic busy_reg;
  logic [11:0] result_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  // conversion sequencing
  conv_state_t state_reg;
  logic [4:0] clk_count_reg;
  logic tick;
  logic sar_load;
  logic [11:0] trial;
  logic finish;
  // bus access decode
  logic access;
  logic wr_ctrl0;
  logic wr_int;

  // true when the code selects an external pin
  function automatic logic is_external(input logic [3:0] code);
    is_external = (code == 4'h0) || (code == 4'h4) || (code[3:2] == 2'b11);
  endfunction

  // byte lane 0 carries every 8-bit register
  function automatic logic [7:0] lane0(input logic [31:0] d);
    lane0 = d[7:0];
  endfunction

  // one access per cycle; ack drops the cycle after it is given
  assign access = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_ctrl0 = access && wb_we_i && wb_sel_i[0]
                    && wb_adr_i == OFF_CTRL0;
  assign wr_int = access && wb_we_i && wb_sel_i[0] && wb_adr_i == OFF_INT;

  // ack one cycle after the strobe, for mapped and unmapped alike
  always_ff @(posedge mclk) begin
    if (reset) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access;
    end
  end
  assign wb_ack_o = ack_reg;

  // control register 0 writable fields; busy is read-only
  always_ff @(posedge mclk) begin
    if (reset) begin
      start_reg <= 1'b0;
      power_reg <= 1'b0;
      align_reg <= 1'b0;
      chan_reg <= 2'h0;
    end else if (wr_ctrl0) begin
      start_reg <= wb_dat_i[CTRL0_START];
      power_reg <= wb_dat_i[CTRL0_PWR];
      align_reg <= wb_dat_i[CTRL0_ALIGN];
      chan_reg <= wb_dat_i[1:0];
    end
  end

  // remaining control registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      src_reg <= 4'h0;
      div_reg <= 3'h0;
      ctrl2_reg <= CTRL_RESET;
      pinsel_reg <= '0;
    end else if (access && wb_we_i && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        OFF_CTRL1: begin
          src_reg <= wb_dat_i[7:4];
          div_reg <= wb_dat_i[2:0];
        end
        OFF_CTRL2: ctrl2_reg <= lane0(wb_dat_i) & 8'h9f;
        OFF_PINSEL: pinsel_reg <= wb_dat_i[PINS-1:0];
        default: begin
          // other offsets hold nothing writable here
        end
      endcase
    end
  end

  // interrupt enables and request; completion beats a clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      gie_reg <= 1'b0;
      cie_reg <= 1'b0;
      req_reg <= 1'b0;
    end else begin
      if (wr_int) begin
        gie_reg <= wb_dat_i[INT_GIE];
        cie_reg <= wb_dat_i[INT_CIE];
      end
      if (finish) begin
        req_reg <= 1'b1;
      end else if (wr_int) begin
        req_reg <= wb_dat_i[INT_REQ];
      end
    end
  end
  // interrupt only when both enables are set
  assign conv_irq = req_reg && gie_reg && cie_reg;

  // read mux, registered so data lines up with ack
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_reg <= 32'h0000_0000;
    end else if (access && !wb_we_i) begin
      unique case (wb_adr_i)
        OFF_CTRL0: rdata_reg <= {24'h0, start_reg, busy_reg, power_reg,
                                 align_reg, 2'b00, chan_reg};
        OFF_CTRL1: rdata_reg <= {24'h0, src_reg, 1'b0, div_reg};
        OFF_CTRL2: rdata_reg <= {24'h0, ctrl2_reg};
        // alignment applied at read time
        OFF_RES_HI: rdata_reg <= align_reg ?
                                 {28'h0, result_reg[11:8]} :
                                 {24'h0, result_reg[11:4]};
        OFF_RES_LO: rdata_reg <= align_reg ?
                                 {24'h0, result_reg[7:0]} :
                                 {24'h0, result_reg[3:0], 4'h0};
        OFF_INT: rdata_reg <= {29'h0, req_reg, cie_reg, gie_reg};
        OFF_PINSEL: rdata_reg <= {{(32-PINS){1'b0}}, pinsel_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end
  assign wb_dat_o = rdata_reg;

  // converter clock divider
  clock_divider u_div (
    .mclk(mclk),
    .reset(reset),
    .clear(state_reg != CV_RUN),
    .div_sel(div_reg),
    .tick(tick)
  );

  // bit-by-bit search engine
  sar_step #(.WIDTH(RES_BITS)) u_sar (
    .mclk(mclk),
    .reset(reset),
    .load(sar_load),
    .step(tick && clk_count_reg >= 5'(SAMPLE_CLKS)),
    .cmp_high(cmp_high),
    .trial(trial),
    .done()
  );

  // last converter clock of the sequence ends the conversion
  assign finish = (state_reg == CV_RUN) && tick
                  && clk_count_reg == LAST_CLK;
  // start search as the sequence begins
  assign sar_load = (state_reg == CV_RESET) && !start_reg;

  // start high holds reset; the falling edge launches the run
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= CV_IDLE;
    end else if (!power_reg) begin
      state_reg <= CV_IDLE; // powered down, nothing runs
    end else if (start_reg) begin
      state_reg <= CV_RESET;
    end else begin
      unique case (state_reg)
        CV_IDLE: state_reg <= CV_IDLE;
        CV_RESET: state_reg <= CV_RUN;
        CV_RUN: state_reg <= finish ? CV_IDLE : CV_RUN;
      endcase
    end
  end

  // converter clock counter: 4 sampling, then 12 conversion
  always_ff @(posedge mclk) begin
    if (reset || state_reg != CV_RUN) begin
      clk_count_reg <= 5'h00;
    end else if (tick) begin
      clk_count_reg <= clk_count_reg + 5'h01;
    end
  end

  // busy from launch to completion
  always_ff @(posedge mclk) begin
    if (reset || !power_reg || start_reg) begin
      busy_reg <= 1'b0;
    end else if (sar_load) begin
      busy_reg <= 1'b1;
    end else if (finish) begin
      busy_reg <= 1'b0;
    end
  end

  // result lands in the same edge busy clears; kept when powered off
  always_ff @(posedge mclk) begin
    if (reset) begin
      result_reg <= 12'h000;
    end else if (finish && power_reg) begin
      // final bit decided on this last tick
      result_reg <= cmp_high ? trial : (trial & 12'hffe);
    end
  end

  // analog side controls
  assign dac_code = trial;
  assign sample_on = (state_reg == CV_RUN)
                     && clk_count_reg < 5'(SAMPLE_CLKS);
  assign conv_reset = (state_reg == CV_RESET);
  assign converter_power = power_reg;

  // input routing: external pin only for external codes
  always_comb begin
    ext_path_on = '0;
    internal_source = 4'h0;
    input_grounded = 1'b0;
    if (is_external(src_reg)) begin
      ext_path_on[chan_reg] = 1'b1;
    end else if (src_reg[3]) begin
      input_grounded = 1'b1;
    end else begin
      // no external path while an internal one is chosen
      unique case (src_reg)
        SRC_VDD: internal_source = 4'h1;
        SRC_VDD2: internal_source = 4'h2;
        SRC_VDD4: internal_source = 4'h3;
        SRC_AMP: internal_source = 4'h5;
        SRC_AMP2: internal_source = 4'h6;
        SRC_AMP4: internal_source = 4'h7;
        default: internal_source = 4'h0;
      endcase
    end
  end

  // reference one-hot: supply, pin, amplifier
  always_comb begin
    reference_route = 3'b000;
    if (ctrl2_reg[CTRL2_REF_LSB+1]) begin
      reference_route = 3'b100;
    end else if (ctrl2_reg[CTRL2_REF_LSB]) begin
      reference_route = 3'b010;
    end else begin
      reference_route = 3'b001;
    end
  end

  // analog pins drop other functions, pull-up and direction
  assign pin_analog_mode = pinsel_reg;
  assign pin_pullup_disable = pinsel_reg;
  assign pin_dir_override = pinsel_reg;
endmodule

// [dv/sar_conv_ctrl_properties.sv]
// checker for the converter control: bus handshake, routing, hold
// bound onto sar_conv_ctrl; sees only its ports, one clock domain
`timescale 1ns/1ps
module sar_conv_ctrl_properties #(
  parameter int PINS = 4
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic sample_on,
  input wire logic conv_reset,
  input wire logic converter_power,
  input wire logic [PINS-1:0] ext_path_on,
  input wire logic [3:0] internal_source,
  input wire logic input_grounded,
  input wire logic [2:0] reference_route,
  input wire logic [PINS-1:0] pin_analog_mode,
  input wire logic [PINS-1:0] pin_pullup_disable,
  input wire logic [PINS-1:0] pin_dir_override
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  // request not yet answered
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // ack lasts exactly one cycle
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_one_cycle: assert property (s_req |=> s_ack_pulse)
    else $error("ack not a single pulse after request");
  a_ext_one_pin: assert property ($onehot0(ext_path_on))
    else $error("more than one external pin connected");
  a_internal_isolated: assert property (internal_source != 4'h0
    |-> ext_path_on == '0 && !input_grounded)
    else $error("internal source joined to another path");
  a_ground_isolated: assert property (input_grounded
    |-> ext_path_on == '0 && internal_source == 4'h0)
    else $error("grounded input joined to another path");
  a_ref_one_route: assert property ($onehot(reference_route))
    else $error("reference route not one-hot");
  a_pin_override: assert property (pin_analog_mode == pin_pullup_disable
    && pin_analog_mode == pin_dir_override)
    else $error("analog pin without pull-up or direction override");
  // power-down takes one edge to reach the sequencer
  a_power_gates: assert property (!converter_power |=> !sample_on)
    else $error("sampling goes on after converter powered off");
  // sampling only ever follows a held converter reset
  a_start_holds: assert property ($rose(sample_on) |-> $past(conv_reset))
    else $error("sampling began without a preceding start pulse");
endmodule

bind sar_conv_ctrl sar_conv_ctrl_properties #(.PINS(PINS)) u_props (
  .mclk, .reset, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .sample_on,
  .conv_reset, .converter_power, .ext_path_on, .internal_source,
  .input_grounded, .reference_route, .pin_analog_mode,
  .pin_pullup_disable, .pin_dir_override
);

// [dv/sar_conv_ctrl_test.sv]
// self-checking bench for the converter control block
// assumes bus master on mclk; comparator modelled against a target
`timescale 1ns/1ps
module sar_conv_ctrl_test;
  import conv_ctrl_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, sample_on, conv_reset, converter_power;
  logic input_grounded, conv_irq, cmp_high;
  logic [11:0] dac_code;
  logic [11:0] target = 12'ha5c; // analog level being converted
  logic [3:0] ext_path_on, internal_source;
  logic [3:0] pin_analog_mode, pin_pullup_disable, pin_dir_override;
  logic [2:0] reference_route;
  int errors = 0;
  int tests_run = 0;
  int scount = 0; // mclk cycles spent sampling
  always #10 mclk = ~mclk; // 50 MHz
  // comparator stand-in: keep the probed bit while trial <= target
  assign cmp_high = (dac_code <= target);
  always @(posedge mclk) if (sample_on) scount <= scount + 1;
  sar_conv_ctrl u_dut (.mclk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cmp_high,
    .dac_code, .sample_on, .conv_reset, .converter_power, .ext_path_on,
    .internal_source, .input_grounded, .reference_route,
    .pin_analog_mode, .pin_pullup_disable, .pin_dir_override, .conv_irq);
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one classic cycle; waits for ack with no cycle limit
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1);
    chk("ack latency", 32'd2, 32'(n));
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    repeat (2) @(negedge mclk); // let register outputs settle
  endtask
  task automatic rdchk(input string what, input logic [7:0] a,
      input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(what, {24'h0, exp}, rd);
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  // expected {internal_source, input_grounded, ext_path_on}, pin 2
  function automatic logic [8:0] route(input logic [3:0] c);
    if (c inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7}) return {c, 5'h00};
    if (c[3:2] == 2'b10) return 9'h010;
    return 9'h004;
  endfunction
  // start held high, released, polled to completion
  task automatic convert(input logic [2:0] d);
    int n;
    n = 0;
    wr(OFF_CTRL1, {5'h0, d});
    wr(OFF_CTRL0, 8'ha0);
    repeat (20) @(posedge mclk);
    chk("converter_power", 32'h1, {31'h0, converter_power});
    chk("conv_reset", 32'h1, {31'h0, conv_reset});
    chk("sample_on", 32'h0, {31'h0, sample_on});
    scount = 0;
    wr(OFF_CTRL0, 8'h20);
    rdchk("busy set", OFF_CTRL0, 8'h60);
    do begin
      bus(1'b0, OFF_CTRL0, 8'h00);
      n++;
    end while (rd[6] !== 1'b0 && n < 2000);
    chk("busy clear", 32'h0, {31'h0, rd[6]});
    chk("sample cycles", 32'(4 << d), scount);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #(20 * 40000);
    errors++;
    $display("[FAIL] watchdog expected finish seen timeout");
    complete_run();
  end
  initial begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    chk("reference_route", 32'h1, {29'h0, reference_route});
    rdchk("ctrl0 reset", OFF_CTRL0, 8'h00);
    rdchk("unmapped", 8'h20, 8'h00);
    done("reset");
    wr(OFF_CTRL0, 8'h02);
    for (int c = 0; c < 16; c++) begin
      wr(OFF_CTRL1, 8'(c << 4));
      chk("routing", 32'(route(4'(c))),
        {23'h0, internal_source, input_grounded, ext_path_on});
    end
    for (int r = 0; r < 4; r++) begin
      wr(OFF_CTRL2, 8'(r << 2));
      chk("reference", (r == 0) ? 1 : (r == 1) ? 2 : 4,
        {29'h0, reference_route});
    end
    wr(OFF_PINSEL, 8'h0a);
    chk("pins", 32'haaa, {20'h0, pin_analog_mode,
      pin_pullup_disable, pin_dir_override});
    done("routing");
    wr(OFF_INT, 8'h03);
    convert(3'h0);
    chk("conv_irq", 32'h1, {31'h0, conv_irq});
    rdchk("request", OFF_INT, 8'h07);
    rdchk("left high", OFF_RES_HI, 8'ha5);
    rdchk("left low", OFF_RES_LO, 8'hc0);
    wr(OFF_CTRL0, 8'h30);
    rdchk("right high", OFF_RES_HI, 8'h0a);
    rdchk("right low", OFF_RES_LO, 8'h5c);
    wr(OFF_INT, 8'h00);
    chk("irq masked", 32'h0, {31'h0, conv_irq});
    convert(3'h3);
    convert(3'h7);
    done("conversion");
    @(posedge mclk) target <= 12'h123;
    wr(OFF_CTRL0, 8'ha0);
    wr(OFF_CTRL0, 8'h20);
    repeat (40) @(posedge mclk);
    wr(OFF_CTRL0, 8'h00);
    chk("power off", 32'h0, {31'h0, converter_power});
    repeat (2100) @(posedge mclk);
    rdchk("aborted busy", OFF_CTRL0, 8'h00);
    rdchk("kept high", OFF_RES_HI, 8'ha5);
    rdchk("kept low", OFF_RES_LO, 8'hc0);
    convert(3'h0);
    rdchk("new high", OFF_RES_HI, 8'h12);
    done("abort");
    complete_run();
  end
endmodule
